// file: clock_generator.sv
// How it works
// - reset loads control register with 02, slow divide-by-four clock selected
// - divide-select 0 gives oscillator clock, 1 gives oscillator over four
// - old clock kept for 2 of its own ticks: 2 clocks going slow, up to 8 going fast
// - oscillator held stopped while active-low reset is low
// - after reset oscillator starts and stabilisation wait precedes cpu run
// - stop instruction halts oscillator
// - peripheral clocks divided from system clock, stop with it
// - stop and halt standby modes are supported
// - control register accepts bit and byte writes
`timescale 1ns/1ps
module clock_generator
  import clkgen_pkg::*;
#(
  parameter int STAB_COUNT = STAB_CYCLES
)
(
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        nrst_i,
  // internal bus
  input  wire logic [15:0] bus_addr_i,
  input  wire logic        bus_wr_i,
  input  wire logic        bus_bit_i,
  input  wire logic [2:0]  bus_bit_sel_i,
  input  wire logic [7:0]  bus_wdata_i,
  input  wire logic        bus_rd_i,
  output logic      [7:0]  bus_rdata_o,
  // standby requests
  input  wire logic        stop_req_i,
  input  wire logic        halt_req_i,
  input  wire logic        wake_i,
  // clock outputs
  output logic             osc_run_o,
  output logic             cpu_clk_en_o,
  output logic             cpu_run_o,
  output logic             slow_sel_o,
  output logic             halted_o,
  output logic      [7:0]  periph_div_o
);
  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  logic [7:0]    ctrl_reg;
  logic [7:0]    ctrl_next;
  gen_state_type state_reg;
  logic [15:0]   stab_reg;
  logic          halt_reg;
  logic          slow_reg;
  logic [2:0]    phase_reg;
  logic [2:0]    wait_reg;
  logic          osc_run;
  logic          tick;
  logic          sel_hit;
  logic          switch_pending;
  logic [7:0]    keep_mask;

  assign sel_hit = bus_addr_i == CPU_CLOCK_CONTROL_ADDR;

  // only the divide-select bit has a flip-flop behind it
  assign keep_mask = 8'h01 << DIVIDE_SELECT_POS;

  always_comb
  begin
    ctrl_next = ctrl_reg;
    if (bus_wr_i && sel_hit)
    begin
      if (bus_bit_i)
        ctrl_next[bus_bit_sel_i] = bus_wdata_i[0];
      else
        ctrl_next = bus_wdata_i;
    end
  end

  // only the divide-select bit is stored; others read zero
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      ctrl_reg <= CPU_CLOCK_CONTROL_RESET;
    else
      ctrl_reg <= ctrl_next & keep_mask;
  end

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      bus_rdata_o <= 8'h00;
    else if (bus_rd_i && sel_hit)
      bus_rdata_o <= ctrl_reg;
    else
      bus_rdata_o <= 8'h00;
  end

  // ----------------------------------------------------------------
  // oscillator sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      state_reg <= ST_RESET;
    else
    begin
      case (state_reg)
        ST_RESET:
          state_reg <= ST_STABLE;
        ST_STABLE:
        begin
          if (stab_reg == 16'(STAB_COUNT - 1))
            state_reg <= ST_RUN;
        end
        ST_RUN:
        begin
          if (stop_req_i)
            state_reg <= ST_STOP;
        end
        ST_STOP:
        begin
          if (wake_i)
            state_reg <= ST_STABLE;
        end
        default:
          state_reg <= ST_RESET;
      endcase
    end
  end

  // the counter runs on the fresh oscillator and restarts on every entry, so a
  // wake from stop gets the full wait again; the cpu waits it out
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      stab_reg <= 16'h0000;
    else if (state_reg != ST_STABLE)
      stab_reg <= 16'h0000;
    else if (stab_reg != 16'(STAB_COUNT - 1))
      stab_reg <= stab_reg + 16'h0001;
  end

  assign osc_run = state_reg == ST_STABLE || state_reg == ST_RUN;

  // ----------------------------------------------------------------
  // standby
  // ----------------------------------------------------------------
  // halt stops only the cpu clock, oscillator keeps running
  // a halt request beats a wake in the same cycle so the request is not lost
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      halt_reg <= 1'b0;
    else if (state_reg != ST_RUN)
      halt_reg <= 1'b0;
    else if (halt_req_i)
      halt_reg <= 1'b1;
    else if (wake_i)
      halt_reg <= 1'b0;
  end

  // ----------------------------------------------------------------
  // cpu clock selection
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      phase_reg <= 3'h0;
    else if (osc_run)
      phase_reg <= (phase_reg == 3'(SLOW_DIV - 1)) ? 3'h0 : phase_reg + 3'h1;
  end

  // tick marks one cpu clock of the current selection
  assign tick = osc_run && (!slow_reg || phase_reg == 3'h0);

  // a pending switch keeps the old clock running until its second tick
  assign switch_pending = slow_reg != ctrl_reg[DIVIDE_SELECT_POS];

  // new selection applied after two old cpu clocks, always at a tick, so the
  // slow period is never cut short; worst case is 2 clocks going slow and 8 going fast
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      slow_reg <= 1'b1;
      wait_reg <= 3'h0;
    end
    else if (!switch_pending)
      wait_reg <= 3'h0;
    else if (tick)
    begin
      if (wait_reg == 3'(SWITCH_FAST_CLOCKS - 1))
      begin
        slow_reg <= ctrl_reg[DIVIDE_SELECT_POS];
        wait_reg <= 3'h0;
      end
      else
        wait_reg <= wait_reg + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // status outputs
  // ----------------------------------------------------------------
  // the enable stays combinational: it is the strobe the cpu steps on
  assign cpu_clk_en_o = tick && state_reg == ST_RUN && !halt_reg;
  assign cpu_run_o    = state_reg == ST_RUN;
  assign osc_run_o    = osc_run;
  assign slow_sel_o   = slow_reg;
  assign halted_o     = halt_reg || state_reg == ST_STOP;

  // ----------------------------------------------------------------
  // peripheral divider
  // ----------------------------------------------------------------
  clk_divider #(
    .WIDTH (PERIPH_DIV_WIDTH)
  ) u_periph_div (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .run_i      (osc_run),
    .count_o    (periph_div_o)
  );
endmodule

// file: clkgen_pkg.sv
package clkgen_pkg;
  // register map
  localparam logic [15:0] CPU_CLOCK_CONTROL_ADDR  = 16'hFFFB;
  localparam logic [7:0]  CPU_CLOCK_CONTROL_RESET = 8'h02;
  localparam int          DIVIDE_SELECT_POS       = 1;
  // timing
  localparam int          STAB_EXP                = 15;
  localparam int          STAB_CYCLES             = 32768;
  localparam int          SLOW_DIV                = 4;
  localparam int          SWITCH_SLOW_CLOCKS      = 4;
  localparam int          SWITCH_FAST_CLOCKS      = 2;
  localparam int          PERIPH_DIV_WIDTH        = 8;
  // sequencer states
  typedef enum logic [3:0]
  {
    ST_RESET  = 4'h1,
    ST_STABLE = 4'h2,
    ST_RUN    = 4'h4,
    ST_STOP   = 4'h8
  } gen_state_type;
endpackage

// file: clk_divider.sv
`timescale 1ns/1ps
module clk_divider
  import clkgen_pkg::*;
#(
  parameter int WIDTH = PERIPH_DIV_WIDTH
)
(
  // clock and reset
  input  wire logic             core_clk_i,
  input  wire logic             nrst_i,
  // control
  input  wire logic             run_i,
  // count
  output logic      [WIDTH-1:0] count_o
);
  // free counter gated by oscillator run state
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      count_o <= '0;
    else if (run_i)
      count_o <= count_o + {{(WIDTH-1){1'b0}}, 1'b1};
  end
endmodule

// file: clock_generator_assertions.sv
`timescale 1ns/1ps
module clock_generator_assertions
  import clkgen_pkg::*;
#(
  parameter int STAB_COUNT = STAB_CYCLES
)
(
  input wire logic        core_clk_i,
  input wire logic        nrst_i,
  input wire logic [15:0] bus_addr_i,
  input wire logic        bus_wr_i,
  input wire logic        bus_bit_i,
  input wire logic [7:0]  bus_wdata_i,
  input wire logic        stop_req_i,
  input wire logic        osc_run_o,
  input wire logic        cpu_clk_en_o,
  input wire logic        cpu_run_o,
  input wire logic        slow_sel_o,
  input wire logic        halted_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  wire act  = cpu_run_o && !halted_o;
  wire slow = bus_wr_i && !bus_bit_i && bus_addr_i == CPU_CLOCK_CONTROL_ADDR
              && bus_wdata_i == CPU_CLOCK_CONTROL_RESET;
  wire fast = bus_wr_i && !bus_bit_i && bus_addr_i == CPU_CLOCK_CONTROL_ADDR
              && bus_wdata_i == 8'h00;
  // cycles the oscillator has run without a break; a deep $past would crawl
  logic [15:0] osc_cnt;
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      osc_cnt <= 16'h0000;
    else if (!osc_run_o)
      osc_cnt <= 16'h0000;
    else if (osc_cnt != 16'hFFFF)
      osc_cnt <= osc_cnt + 16'h0001;
  end
  a_run_needs_osc: assert property (cpu_run_o |-> osc_run_o)
    else $error("cpu runs without oscillator");
  a_stab_wait: assert property ($rose(cpu_run_o) |-> osc_cnt == 16'(STAB_COUNT))
    else $error("stabilisation wait too short");
  a_tick_in_run: assert property (cpu_clk_en_o |-> act)
    else $error("cpu tick outside run");
  a_fast_each: assert property (act && !slow_sel_o |-> cpu_clk_en_o)
    else $error("fast clock missed a tick");
  a_slow_gap: assert property (cpu_clk_en_o && slow_sel_o |=> !cpu_clk_en_o || !slow_sel_o)
    else $error("slow clock ticked twice in a row");
  a_stop_osc: assert property (act && stop_req_i |=> !osc_run_o && halted_o)
    else $error("stop left oscillator running");
  a_sel_at_tick: assert property ($changed(slow_sel_o) |-> $past(cpu_clk_en_o))
    else $error("clock switched off a tick");
  a_to_slow: assert property (act && !slow_sel_o && slow |-> ##[1:4] slow_sel_o)
    else $error("switch to slow too late");
  a_to_fast: assert property (act && slow_sel_o && fast |-> ##[1:9] !slow_sel_o)
    else $error("switch to fast too late");
endmodule
bind clock_generator clock_generator_assertions #(.STAB_COUNT(STAB_COUNT)) chk_inst (.*);

// file: cpu_tick_consumer.sv
`timescale 1ns/1ps
module cpu_tick_consumer
(
  input  wire logic        core_clk_i,
  input  wire logic        nrst_i,
  input  wire logic        cpu_clk_en_i,
  output logic      [15:0] ticks_o
);
  // one cpu step per enable pulse
  always_ff @(posedge core_clk_i or negedge nrst_i)
    if (!nrst_i) ticks_o <= 16'h0000;
    else if (cpu_clk_en_i) ticks_o <= ticks_o + 16'h0001;
endmodule

// file: clock_generator_tb.sv
`timescale 1ns/1ps
module clock_generator_tb;
  import clkgen_pkg::*;
  logic        clk = 0, nrst = 0, wr = 0, bb = 0, rd = 0, stp = 0, hlt = 0, wk = 0;
  logic [15:0] addr = 16'hFFFB, tk, t0;
  logic [7:0]  wd = 8'h00, rdata, pdiv, pd0;
  logic [2:0]  bsel = 3'h1;
  logic        osc, en, run, slow, hal;
  int          err_total = 0, n_compared = 0, i;
  clock_generator #(.STAB_COUNT(16)) clock_generator_inst (.core_clk_i(clk), .nrst_i(nrst),
    .bus_addr_i(addr), .bus_wr_i(wr), .bus_bit_i(bb), .bus_bit_sel_i(bsel), .bus_wdata_i(wd),
    .bus_rd_i(rd), .bus_rdata_o(rdata), .stop_req_i(stp), .halt_req_i(hlt), .wake_i(wk),
    .osc_run_o(osc), .cpu_clk_en_o(en), .cpu_run_o(run), .slow_sel_o(slow),
    .halted_o(hal), .periph_div_o(pdiv));
  cpu_tick_consumer cpu_tick_consumer_inst (.core_clk_i(clk), .nrst_i(nrst),
    .cpu_clk_en_i(en), .ticks_o(tk));
  initial forever #4 clk = ~clk;
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e)
    begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // bus access: w=1 write, b=1 bit write of the bit in bsel
  task automatic acc(input logic w, input logic b, input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    {addr, wd, bb, wr, rd} = {a, d, b, w, !w};
    @(negedge clk);
    {wr, rd} = 2'b00;
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1;
    @(negedge clk);
    s = 0;
  endtask
  task automatic rate(input int n, input logic [15:0] e);
    t0 = tk;
    repeat (n) @(negedge clk);
    chk(tk - t0, e);
  endtask
  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(negedge clk);
    chk({osc, slow}, 2'b01);
    nrst = 1;
    repeat (16) @(negedge clk);
    chk({osc, run}, 2'b10);
    @(negedge clk);
    chk(run, 1);
    acc(0, 0, 16'hFFFB, 0); chk(rdata, CPU_CLOCK_CONTROL_RESET);
    rate(40, 10);
    acc(1, 0, 16'hFFFB, 8'h00);
    repeat (9) @(negedge clk);
    chk(slow, 0);
    acc(0, 0, 16'hFFFB, 0); chk(rdata, 0);
    rate(40, 40);
    acc(1, 1, 16'hFFFB, 8'h01);
    repeat (4) @(negedge clk);
    chk(slow, 1);
    acc(0, 0, 16'hFFFB, 0); chk(rdata, 8'h02);
    bsel = 3'h0;
    acc(1, 1, 16'hFFFB, 8'h00);
    bsel = 3'h1;
    acc(0, 0, 16'hFFFB, 0); chk({rdata, slow}, 9'h005);
    acc(1, 0, 16'hFFFA, 0); acc(0, 0, 16'hFFFA, 0); chk({rdata, slow}, 9'h001);
    pulse(hlt); chk({hal, osc, en}, 3'b110);
    pulse(wk); chk(hal, 0);
    rate(40, 10);
    pulse(stp); chk({hal, osc}, 2'b10);
    pd0 = pdiv;
    repeat (5) @(negedge clk);
    chk(pdiv, pd0);
    pulse(wk);
    for (i = 0; i < 100 && run !== 1'b1; i++) @(negedge clk);
    chk(run, 1);
    pd0 = pdiv;
    repeat (8) @(negedge clk);
    chk(8'(pdiv - pd0), 16'h0008);
    acc(1, 0, 16'hFFFB, 8'h00);
    repeat (9) @(negedge clk);
    chk(slow, 0);
    acc(1, 0, 16'hFFFB, 8'h02);
    repeat (3) @(negedge clk);
    chk(slow, 1);
    acc(1, 0, 16'hFFFB, 8'h00);
    repeat (9) @(negedge clk);
    chk(slow, 0);
    nrst = 0;
    @(negedge clk);
    chk({osc, run, slow}, 3'b001);
    nrst = 1;
    for (i = 0; i < 100 && run !== 1'b1; i++) @(negedge clk);
    chk(i, 17);
    acc(0, 0, 16'hFFFB, 0); chk({rdata, slow}, 9'h005);
    summarize();
  end
endmodule
